// File: hw/port_set_and_compare_skip_ops.sv
// port bit set, compare-and-skip and ext0 flag skip execution
//
// What this block does
// - set_port_bit_op, one word one cycle, sets port bit chosen by index
// - port has six bits, so only index values 0 to 5 are valid
// - compare_imm_skip_op is two words, two cycles, 4-bit immediate
// - compare_imm_skip_op skips next instruction when nibble equals immediate
// - compare_mem_skip_op skips next when nibble equals memory nibble
// - ext0_flag_skip_op is one word, one cycle, carry untouched
// - with mode bit 0 and flag set: skip next, then clear flag
// - mode bit is control bit 0; when 1 the op is a no-operation
`timescale 1ns/1ps
module port_set_and_compare_skip_ops (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic instrValid,
    input wire skip_ops_pkg::word_t instrWord,
    input wire skip_ops_pkg::nib_t workingNibble,
    input wire skip_ops_pkg::nib_t bitSelect,
    input wire skip_ops_pkg::nib_t memNibble,
    input wire skip_ops_pkg::nib_t intCtrlOne,
    input wire logic ext0Event,
    output logic [skip_ops_pkg::PORT_W-1:0] portOut,
    output logic skipNextOut,
    output logic ext0FlagOut,
    output logic operandWaitOut
);
    import skip_ops_pkg::*;

    seq_state_e state_reg;
    logic [PORT_W-1:0] port_reg;
    logic skip_reg;
    logic ext0_reg;
    logic wait_reg;

    decode_if decBus ();

    assign decBus.word = instrWord;

    opcode_decoder u_decoder (
        .bus(decBus.dec)
    );

    logic execIdle;
    logic modeLocked;
    logic bitInRange;
    logic seamHit;
    logic snzHit;
    logic seaHit;
    logic swallowDone;
    logic skipSet;
    seq_state_e state_next;

    // a word arriving while a skip is pending is discarded, not executed
    assign execIdle = instrValid && !skip_reg && (state_reg == ST_IDLE);
    assign modeLocked = intCtrlOne[SKIP_MODE_BIT];
    assign bitInRange = (bitSelect <= PORT_MAX_INDEX);
    assign seamHit = execIdle && decBus.isSeam
        && (workingNibble == memNibble);
    assign snzHit = execIdle && decBus.isSnz0 && !modeLocked
        && ext0_reg;
    // immediate sits in the low nibble of the second word
    assign seaHit = instrValid && (state_reg == ST_OPERAND)
        && (workingNibble == instrWord[NIB_W-1:0]);
    // a skipped two-word compare also swallows its operand word
    assign swallowDone = instrValid
        && (((state_reg == ST_IDLE) && skip_reg && !decBus.isSeaFirst)
        || (state_reg == ST_SKIP_OPERAND));
    assign skipSet = seamHit || snzHit || seaHit;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (instrValid && decBus.isSeaFirst) begin
                    state_next = skip_reg ? ST_SKIP_OPERAND
                        : ST_OPERAND;
                end
            end
            ST_OPERAND: begin
                if (instrValid) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SKIP_OPERAND: begin
                if (instrValid) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= (state_next != ST_IDLE);
        end
    end

    // no carry is kept here: none of these ops may touch it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port_reg <= PORT_RESET;
        end else if (execIdle && decBus.isSetBit && bitInRange) begin
            port_reg[bitSelect[2:0]] <= 1'b1;
        end
        // out-of-range index falls through and leaves the port alone
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            skip_reg <= SKIP_RESET;
        end else if (skipSet) begin
            skip_reg <= 1'b1;
        end else if (swallowDone) begin
            skip_reg <= 1'b0;
        end
    end

    // a new request in the clearing cycle wins, so no event is lost
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ext0_reg <= EXT0_RESET;
        end else if (ext0Event) begin
            ext0_reg <= 1'b1;
        end else if (snzHit) begin
            ext0_reg <= 1'b0;
        end
    end

    assign portOut = port_reg;
    assign skipNextOut = skip_reg;
    assign ext0FlagOut = ext0_reg;
    assign operandWaitOut = wait_reg;

    property p_set_bit;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSetBit && bitInRange) |=>
            (port_reg == ($past(port_reg)
            | (PORT_ONE << $past(bitSelect[2:0]))));
    endproperty
    a_set_bit: assert property (p_set_bit)
        else $error("port bit not set by set op");

    property p_range_nop;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSetBit && !bitInRange) |=>
            ($stable(port_reg) && !skip_reg && $stable(state_reg));
    endproperty
    a_range_nop: assert property (p_range_nop)
        else $error("out of range set op changed state");

    property p_port_only_by_set;
        @(posedge mclk) disable iff (sys_rst)
        !(execIdle && decBus.isSetBit) |=> $stable(port_reg);
    endproperty
    a_port_only_by_set: assert property (p_port_only_by_set)
        else $error("port changed without a set op");

    property p_imm_two_words;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSeaFirst) |=>
            (wait_reg && !skip_reg && (state_reg == ST_OPERAND));
    endproperty
    a_imm_two_words: assert property (p_imm_two_words)
        else $error("immediate compare did not wait for operand");

    property p_imm_skip;
        @(posedge mclk) disable iff (sys_rst)
        (instrValid && (state_reg == ST_OPERAND)) |=>
            (skip_reg == $past(workingNibble == instrWord[3:0]))
            && !wait_reg;
    endproperty
    a_imm_skip: assert property (p_imm_skip)
        else $error("immediate compare skip wrong");

    property p_mem_skip;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSeam) |=>
            (skip_reg == $past(workingNibble == memNibble));
    endproperty
    a_mem_skip: assert property (p_mem_skip)
        else $error("memory compare skip wrong");

    property p_ext0_skip;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSnz0 && !modeLocked) |=>
            (skip_reg == $past(ext0_reg));
    endproperty
    a_ext0_skip: assert property (p_ext0_skip)
        else $error("ext0 skip decision wrong");

    property p_ext0_clear;
        @(posedge mclk) disable iff (sys_rst)
        (snzHit && !ext0Event) |=> !ext0_reg;
    endproperty
    a_ext0_clear: assert property (p_ext0_clear)
        else $error("ext0 flag not cleared after skip");

    property p_ext0_locked;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSnz0 && modeLocked) |=>
            !skip_reg && (ext0_reg == $past(ext0_reg || ext0Event));
    endproperty
    a_ext0_locked: assert property (p_ext0_locked)
        else $error("locked ext0 op acted");

    property p_one_cycle_ops;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && (decBus.isSeam || decBus.isSnz0
            || decBus.isSetBit)) |=> !wait_reg;
    endproperty
    a_one_cycle_ops: assert property (p_one_cycle_ops)
        else $error("single word op held the sequencer");

    property p_snz_one_cycle;
        @(posedge mclk) disable iff (sys_rst)
        (execIdle && decBus.isSnz0) |=> (state_reg == ST_IDLE);
    endproperty
    a_snz_one_cycle: assert property (p_snz_one_cycle)
        else $error("ext0 op left sequencer busy");

    property p_event_wins;
        @(posedge mclk) disable iff (sys_rst)
        ext0Event |=> ext0_reg [*1] ##1 (ext0_reg || $past(snzHit));
    endproperty
    a_event_wins: assert property (p_event_wins)
        else $error("ext0 request lost");

    property p_swallow;
        @(posedge mclk) disable iff (sys_rst)
        (skip_reg && instrValid && (state_reg == ST_IDLE)
            && !decBus.isSeaFirst) |=> !skip_reg && $stable(port_reg);
    endproperty
    a_swallow: assert property (p_swallow)
        else $error("skipped word was executed");
endmodule : port_set_and_compare_skip_ops

// File: hw/skip_ops_pkg.sv
// constants and types shared by the port-set and compare-skip logic
package skip_ops_pkg;
    localparam int WORD_W = 10;
    localparam int NIB_W = 4;
    localparam int PORT_W = 6;
    localparam logic [3:0] PORT_MAX_INDEX = 4'h5;
    localparam int SKIP_MODE_BIT = 0;
    localparam logic [9:0] OP_SET_PORT_BIT = 10'h015;
    localparam logic [9:0] OP_COMPARE_MEM = 10'h04c;
    localparam logic [9:0] OP_EXT0_SKIP = 10'h070;
    localparam logic [9:0] OP_COMPARE_IMM = 10'h025;
    localparam logic [5:0] OP_IMM_PREFIX = 6'h07;
    localparam logic [5:0] PORT_RESET = 6'h00;
    localparam logic EXT0_RESET = 1'b0;
    localparam logic SKIP_RESET = 1'b0;
    localparam logic [5:0] PORT_ONE = 6'h01;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [NIB_W-1:0] nib_t;

    // gray step along idle -> operand only; idle -> operand skip flips both bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPERAND = 2'b01,
        ST_SKIP_OPERAND = 2'b11
    } seq_state_e;
endpackage : skip_ops_pkg

// File: hw/decode_if.sv
// instruction word and decoded opcode flags between top and decoder
`timescale 1ns/1ps
interface decode_if;
    import skip_ops_pkg::*;
    word_t word;
    logic isSetBit;
    logic isSeaFirst;
    logic isSeam;
    logic isSnz0;
    modport dec (
        input word,
        output isSetBit,
        output isSeaFirst,
        output isSeam,
        output isSnz0
    );
    modport user (
        output word,
        input isSetBit,
        input isSeaFirst,
        input isSeam,
        input isSnz0
    );
endinterface : decode_if

// File: hw/opcode_decoder.sv
// full ten-bit opcode match for the four handled instructions
`timescale 1ns/1ps
module opcode_decoder (
    decode_if.dec bus
);
    import skip_ops_pkg::*;

    // exact compares: any other word is left to the rest of the core
    always_comb begin
        bus.isSetBit = (bus.word == OP_SET_PORT_BIT);
        bus.isSeaFirst = (bus.word == OP_COMPARE_IMM);
        bus.isSeam = (bus.word == OP_COMPARE_MEM);
        bus.isSnz0 = (bus.word == OP_EXT0_SKIP);
    end
endmodule : opcode_decoder

// File: tb/port_set_and_compare_skip_ops_tb_top.sv
// self-checking bench for the port-set and compare-skip block
`timescale 1ns/1ps
module port_set_and_compare_skip_ops_tb_top;
    import skip_ops_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic instrValid = 1'b0;
    word_t instrWord = 10'h000;
    nib_t workingNibble = 4'h0;
    nib_t bitSelect = 4'h0;
    nib_t memNibble = 4'h0;
    nib_t intCtrlOne = 4'h0;
    logic ext0Event = 1'b0;
    logic [PORT_W-1:0] portOut;
    logic skipNextOut;
    logic ext0FlagOut;
    logic operandWaitOut;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    port_set_and_compare_skip_ops u_port_set_and_compare_skip_ops (
        .mclk(mclk), .sys_rst(sys_rst), .instrValid(instrValid),
        .instrWord(instrWord), .workingNibble(workingNibble),
        .bitSelect(bitSelect), .memNibble(memNibble),
        .intCtrlOne(intCtrlOne), .ext0Event(ext0Event),
        .portOut(portOut), .skipNextOut(skipNextOut),
        .ext0FlagOut(ext0FlagOut), .operandWaitOut(operandWaitOut)
    );

    always #20 mclk = ~mclk;

    task end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // over thirty times the expected run of about 60 cycles, so a stuck handshake cannot hang the run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_sim();
        end
    end

    task check(input logic [5:0] got, input logic [5:0] exp,
        input string m);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : check

    task check_bit(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %b want %b", $time, m, got, exp);
        end
    endtask : check_bit

    // entered at a falling edge; valid stays up so words can run back to back
    task issue(input word_t w);
        instrValid = 1'b1;
        instrWord = w;
        @(negedge mclk);
    endtask : issue

    task idle;
        instrValid = 1'b0;
        @(negedge mclk);
    endtask : idle

    task mem_compare;
        workingNibble = 4'h9;
        memNibble = 4'h9;
        issue(OP_COMPARE_MEM);
        check_bit(skipNextOut, 1'b1, "mem equal skip");
        check_bit(operandWaitOut, 1'b0, "mem op waited");
        bitSelect = 4'h0;
        issue(OP_SET_PORT_BIT);
        check_bit(skipNextOut, 1'b0, "skip consumed");
        check(portOut, 6'h00, "skipped word acted");
        memNibble = 4'h8;
        issue(OP_COMPARE_MEM);
        check_bit(skipNextOut, 1'b0, "mem unequal skip");
        idle();
    endtask : mem_compare

    task set_bits;
        logic [5:0] exp;
        exp = 6'h00;
        for (int i = 6; i < 16; i++) begin
            bitSelect = nib_t'(i);
            issue(OP_SET_PORT_BIT);
            check(portOut, exp, "bad index acted");
        end
        for (int i = 0; i < 6; i++) begin
            bitSelect = nib_t'(i);
            exp[i] = 1'b1;
            issue(OP_SET_PORT_BIT);
            check(portOut, exp, "port bit set");
            check_bit(skipNextOut, 1'b0, "set op skipped");
        end
        idle();
    endtask : set_bits

    task imm_compare(input nib_t a, input nib_t n, input logic exp);
        workingNibble = a;
        issue(OP_COMPARE_IMM);
        check_bit(operandWaitOut, 1'b1, "operand wait");
        check_bit(skipNextOut, 1'b0, "early skip");
        issue({OP_IMM_PREFIX, n});
        check_bit(operandWaitOut, 1'b0, "operand taken");
        check_bit(skipNextOut, exp, "imm compare skip");
        issue(10'h000);
        check_bit(skipNextOut, 1'b0, "skip consumed");
        idle();
    endtask : imm_compare

    // a skipped two-word compare must swallow its operand, which would hit
    task imm_skipped;
        workingNibble = 4'h5;
        memNibble = 4'h5;
        issue(OP_COMPARE_MEM);
        issue(OP_COMPARE_IMM);
        check_bit(skipNextOut, 1'b1, "operand not swallowed");
        check_bit(operandWaitOut, 1'b1, "skipped pair no wait");
        issue({OP_IMM_PREFIX, 4'h5});
        check_bit(skipNextOut, 1'b0, "skipped operand acted");
        check_bit(operandWaitOut, 1'b0, "stuck after skip");
        idle();
    endtask : imm_skipped

    task ext0_skip;
        ext0Event = 1'b1;
        @(negedge mclk);
        ext0Event = 1'b0;
        check_bit(ext0FlagOut, 1'b1, "flag set");
        intCtrlOne = 4'h1;
        issue(OP_EXT0_SKIP);
        check_bit(skipNextOut, 1'b0, "mode 1 skipped");
        check_bit(ext0FlagOut, 1'b1, "mode 1 cleared flag");
        intCtrlOne = 4'he;
        issue(OP_EXT0_SKIP);
        check_bit(skipNextOut, 1'b1, "flag skip");
        check_bit(ext0FlagOut, 1'b0, "flag clear");
        issue(10'h000);
        issue(OP_EXT0_SKIP);
        check_bit(skipNextOut, 1'b0, "clear flag skipped");
        // a new request in the clearing cycle must survive the clear
        ext0Event = 1'b1;
        idle();
        issue(OP_EXT0_SKIP);
        ext0Event = 1'b0;
        check_bit(skipNextOut, 1'b1, "skip with new event");
        check_bit(ext0FlagOut, 1'b1, "new event lost");
        issue(10'h000);
        check_bit(skipNextOut, 1'b0, "late skip consumed");
        idle();
    endtask : ext0_skip

    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        check_bit(operandWaitOut, 1'b0, "reset wait");
        check_bit(ext0FlagOut, 1'b0, "reset flag");
        check_bit(skipNextOut, 1'b0, "reset skip");
        check(portOut, PORT_RESET, "reset port");
        mem_compare();
        set_bits();
        imm_compare(4'hf, 4'hf, 1'b1);
        imm_compare(4'h0, 4'h0, 1'b1);
        imm_compare(4'h3, 4'h7, 1'b0);
        imm_skipped();
        ext0_skip();
        end_sim();
    end
endmodule : port_set_and_compare_skip_ops_tb_top
